// ### icp_accum_regs.vh
// Purpose : register offsets, field positions, reset values and widths
//           for the integrator chop pulse accumulator
// Assumes : included by every design file of the block
// Notes   : definitions only, no logic
`ifndef ICP_ACCUM_REGS_VH
`define ICP_ACCUM_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define ICP_ADDR_SAMPLE_FREQ   8'h12
`define ICP_ADDR_AVG_COUNT     8'h15
`define ICP_ADDR_POLARITY_A    8'h17
`define ICP_ADDR_OFFSET_A_CH1  8'h18
`define ICP_ADDR_OFFSET_A_CH4  8'h1B
`define ICP_ADDR_POLARITY_B    8'h1D
`define ICP_ADDR_OFFSET_B_CH1  8'h1E
`define ICP_ADDR_OFFSET_B_CH4  8'h21
`define ICP_ADDR_PULSE_CFG_A   8'h31
`define ICP_ADDR_PULSE_CFG_B   8'h36
`define ICP_ADDR_CHOP_MATH     8'h58
`define ICP_ADDR_STATUS        8'h60

// ****************************************************************
// field positions
// ****************************************************************
`define ICP_PCNT_MSB           15
`define ICP_PCNT_LSB           8
`define ICP_AVG_A_MSB          6
`define ICP_AVG_A_LSB          4
`define ICP_AVG_B_MSB          10
`define ICP_AVG_B_LSB          8
`define ICP_POL_MSB            3
`define ICP_POL_LSB            0
`define ICP_M12_A_MSB          2
`define ICP_M12_A_LSB          1
`define ICP_M12_B_MSB          6
`define ICP_M12_B_LSB          5
`define ICP_M34_A_MSB          9
`define ICP_M34_A_LSB          8
`define ICP_M34_B_MSB          11
`define ICP_M34_B_LSB          10

// ****************************************************************
// reset values and widths
// ****************************************************************
`define ICP_RST_REG            16'h0000
`define ICP_ACC_W              27
`define ICP_SUM_W              34
`define ICP_TERM_W             18

`endif

// ### icp_accumulator.v
// Purpose : combines signed pulse results of slots A and B into samples,
//           averages internal samples and drives integrator polarity
// Assumes : one pulse result per strobe, already tagged with its slot
// Notes   : register port is a plain word port at the register offsets
`timescale 1ns/10ps
`default_nettype none
`include "icp_accum_regs.vh"

module icp_accumulator (
  // clock, reset, enable
  input  wire                  i_clk,
  input  wire                  i_rst_b,
  input  wire                  i_ce,
  // register port
  input  wire                  i_reg_wr,
  input  wire                  i_reg_rd,
  input  wire [7:0]            i_reg_addr,
  input  wire [15:0]           i_reg_wdata,
  output reg  [15:0]           o_reg_rdata,
  // pulse results from the converter
  input  wire                  i_pulse_valid,
  input  wire                  i_pulse_slot,
  input  wire [13:0]           i_pulse_data,
  // integrator polarity for each slot's next pulse
  output reg                   o_integ_reverse_a,
  output reg                   o_integ_reverse_b,
  // output samples
  output reg                   o_data_valid,
  output reg                   o_data_slot,
  output reg  [`ICP_ACC_W-1:0] o_data
);

  // ****************************************************************
  // polarity bit of the pulse at a given index within its sample
  // ****************************************************************
  function pol_bit;
    input [3:0] pattern;
    input [7:0] index;
    begin
      pol_bit = pattern[index[1:0]];
    end
  endfunction

  // ****************************************************************
  // true when an address falls in the four-word bank starting at first
  // ****************************************************************
  function in_bank;
    input [7:0] addr;
    input [7:0] first;
    begin
      in_bank = (addr >= first) && (addr <= first + 8'h03);
    end
  endfunction

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg [15:0] sample_frequency_reg;
  reg [15:0] sample_average_count_reg;
  reg [15:0] integration_polarity_a_reg;
  reg [15:0] integration_polarity_b_reg;
  reg [15:0] adc_offset_a_reg [0:3];
  reg [15:0] adc_offset_b_reg [0:3];
  reg [15:0] pulse_config_a_reg;
  reg [15:0] pulse_config_b_reg;
  reg [15:0] chop_math_control_reg;

  // pulse position and running sums per slot
  reg [7:0]             pidx_a_reg;
  reg [7:0]             pidx_b_reg;
  reg [`ICP_ACC_W-1:0]  acc_a_reg;
  reg [`ICP_ACC_W-1:0]  acc_b_reg;
  reg                   smp_a_valid_reg;
  reg                   smp_b_valid_reg;
  reg [`ICP_ACC_W-1:0]  smp_reg;

  // ****************************************************************
  // field extraction
  // ****************************************************************
  wire [7:0] pulse_count_a = pulse_config_a_reg[`ICP_PCNT_MSB:`ICP_PCNT_LSB];
  wire [7:0] pulse_count_b = pulse_config_b_reg[`ICP_PCNT_MSB:`ICP_PCNT_LSB];
  wire [2:0] avg_sel_a =
    sample_average_count_reg[`ICP_AVG_A_MSB:`ICP_AVG_A_LSB];
  wire [2:0] avg_sel_b =
    sample_average_count_reg[`ICP_AVG_B_MSB:`ICP_AVG_B_LSB];
  wire [3:0] pulse_polarity_pattern_slot_a =
    integration_polarity_a_reg[`ICP_POL_MSB:`ICP_POL_LSB];
  wire [3:0] pulse_polarity_pattern_slot_b =
    integration_polarity_b_reg[`ICP_POL_MSB:`ICP_POL_LSB];
  wire [1:0] sign_select_first_pair_slot_a =
    chop_math_control_reg[`ICP_M12_A_MSB:`ICP_M12_A_LSB];
  wire [1:0] sign_select_first_pair_slot_b =
    chop_math_control_reg[`ICP_M12_B_MSB:`ICP_M12_B_LSB];
  wire [1:0] sign_select_second_pair_slot_a =
    chop_math_control_reg[`ICP_M34_A_MSB:`ICP_M34_A_LSB];
  wire [1:0] sign_select_second_pair_slot_b =
    chop_math_control_reg[`ICP_M34_B_MSB:`ICP_M34_B_LSB];

  // ****************************************************************
  // per-pulse selection by slot
  // ****************************************************************
  wire [7:0]  pidx   = i_pulse_slot ? pidx_b_reg : pidx_a_reg;
  wire [7:0]  pcount = i_pulse_slot ? pulse_count_b : pulse_count_a;
  wire [1:0]  math12 = i_pulse_slot ? sign_select_first_pair_slot_b
                                    : sign_select_first_pair_slot_a;
  wire [1:0]  math34 = i_pulse_slot ? sign_select_second_pair_slot_b
                                    : sign_select_second_pair_slot_a;
  // only the channel 1 offset applies to the single result path
  wire [15:0] offset = i_pulse_slot ? adc_offset_b_reg[0]
                                    : adc_offset_a_reg[0];
  wire [`ICP_ACC_W-1:0] acc_sel = i_pulse_slot ? acc_b_reg : acc_a_reg;

  // a count of zero behaves as one so a sample always closes;
  // >= also closes a sample whose count was lowered part way through
  wire last_pulse = (pcount <= 8'h01) || (pidx >= pcount - 8'h01);

  // result after the offset; 18 bits hold the full difference range
  wire signed [`ICP_TERM_W-1:0] pulse_result =
    $signed({4'h0, i_pulse_data}) - $signed({2'b00, offset});
  wire signed [`ICP_TERM_W-1:0] pulse_term;

  icp_pulse_sign u_sign (
    .i_index  (pidx[1:0]),
    .i_math12 (math12),
    .i_math34 (math34),
    .i_result (pulse_result),
    .o_term   (pulse_term)
  );

  // clear on the first pulse so no residue from the last sample leaks in
  wire [`ICP_ACC_W-1:0] acc_base =
    (pidx == 8'h00) ? {`ICP_ACC_W{1'b0}} : acc_sel;
  wire [`ICP_ACC_W-1:0] acc_sum = acc_base
    + {{(`ICP_ACC_W-`ICP_TERM_W){pulse_term[`ICP_TERM_W-1]}}, pulse_term};

  // ****************************************************************
  // next pulse index per slot
  // ****************************************************************
  reg [7:0] pidx_a_next;
  reg [7:0] pidx_b_next;

  always @* begin
    pidx_a_next = pidx_a_reg;
    pidx_b_next = pidx_b_reg;
    if (i_pulse_valid) begin
      // wrap after the programmed number of pulses
      if (i_pulse_slot)
        pidx_b_next = last_pulse ? 8'h00 : pidx_b_reg + 8'h01;
      else
        pidx_a_next = last_pulse ? 8'h00 : pidx_a_reg + 8'h01;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  integer k;

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sample_frequency_reg       <= `ICP_RST_REG;
      sample_average_count_reg   <= `ICP_RST_REG;
      integration_polarity_a_reg <= `ICP_RST_REG;
      integration_polarity_b_reg <= `ICP_RST_REG;
      pulse_config_a_reg         <= `ICP_RST_REG;
      pulse_config_b_reg         <= `ICP_RST_REG;
      chop_math_control_reg      <= `ICP_RST_REG;
      for (k = 0; k < 4; k = k + 1) begin
        adc_offset_a_reg[k] <= `ICP_RST_REG;
        adc_offset_b_reg[k] <= `ICP_RST_REG;
      end
    end else if (i_ce && i_reg_wr) begin
      case (i_reg_addr)
        `ICP_ADDR_SAMPLE_FREQ: sample_frequency_reg       <= i_reg_wdata;
        `ICP_ADDR_AVG_COUNT:   sample_average_count_reg   <= i_reg_wdata;
        `ICP_ADDR_POLARITY_A:  integration_polarity_a_reg <= i_reg_wdata;
        `ICP_ADDR_POLARITY_B:  integration_polarity_b_reg <= i_reg_wdata;
        `ICP_ADDR_PULSE_CFG_A: pulse_config_a_reg         <= i_reg_wdata;
        `ICP_ADDR_PULSE_CFG_B: pulse_config_b_reg         <= i_reg_wdata;
        `ICP_ADDR_CHOP_MATH:   chop_math_control_reg      <= i_reg_wdata;
        default: begin
          // offset banks decoded by range; other addresses drop the write
          if (in_bank(i_reg_addr, `ICP_ADDR_OFFSET_A_CH1))
            adc_offset_a_reg[i_reg_addr[1:0]] <= i_reg_wdata;
          else if (in_bank(i_reg_addr, `ICP_ADDR_OFFSET_B_CH1))
            adc_offset_b_reg[i_reg_addr[1:0] - 2'b10] <= i_reg_wdata;
        end
      endcase
    end
  end

  // ****************************************************************
  // register reads, one cycle after the strobe
  // ****************************************************************
  reg [15:0] rdata_next;

  always @* begin
    rdata_next = 16'h0000;
    case (i_reg_addr)
      `ICP_ADDR_SAMPLE_FREQ: rdata_next = sample_frequency_reg;
      `ICP_ADDR_AVG_COUNT:   rdata_next = sample_average_count_reg;
      `ICP_ADDR_POLARITY_A:  rdata_next = integration_polarity_a_reg;
      `ICP_ADDR_POLARITY_B:  rdata_next = integration_polarity_b_reg;
      `ICP_ADDR_PULSE_CFG_A: rdata_next = pulse_config_a_reg;
      `ICP_ADDR_PULSE_CFG_B: rdata_next = pulse_config_b_reg;
      `ICP_ADDR_CHOP_MATH:   rdata_next = chop_math_control_reg;
      `ICP_ADDR_STATUS:      rdata_next = {pidx_b_reg, pidx_a_reg};
      default: begin
        if (in_bank(i_reg_addr, `ICP_ADDR_OFFSET_A_CH1))
          rdata_next = adc_offset_a_reg[i_reg_addr[1:0]];
        else if (in_bank(i_reg_addr, `ICP_ADDR_OFFSET_B_CH1))
          rdata_next = adc_offset_b_reg[i_reg_addr[1:0] - 2'b10];
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_b)
      o_reg_rdata <= 16'h0000;
    else if (i_ce && i_reg_rd)
      o_reg_rdata <= rdata_next;
  end

  // ****************************************************************
  // pulse accumulation per slot
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      pidx_a_reg      <= 8'h00;
      pidx_b_reg      <= 8'h00;
      acc_a_reg       <= {`ICP_ACC_W{1'b0}};
      acc_b_reg       <= {`ICP_ACC_W{1'b0}};
      smp_a_valid_reg <= 1'b0;
      smp_b_valid_reg <= 1'b0;
      smp_reg         <= {`ICP_ACC_W{1'b0}};
    end else if (i_ce) begin
      smp_a_valid_reg <= 1'b0;
      smp_b_valid_reg <= 1'b0;
      pidx_a_reg      <= pidx_a_next;
      pidx_b_reg      <= pidx_b_next;
      if (i_pulse_valid) begin
        // signed term added into the running sum of its slot
        if (i_pulse_slot)
          acc_b_reg <= acc_sum;
        else
          acc_a_reg <= acc_sum;
        if (last_pulse) begin
          // closed internal sample goes on to the averager
          smp_reg         <= acc_sum;
          smp_a_valid_reg <= ~i_pulse_slot;
          smp_b_valid_reg <= i_pulse_slot;
        end
      end
    end
  end

  // ****************************************************************
  // integrator polarity for the coming pulse of each slot
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_integ_reverse_a <= 1'b0;
      o_integ_reverse_b <= 1'b0;
    end else if (i_ce) begin
      o_integ_reverse_a <=
        pol_bit(pulse_polarity_pattern_slot_a, pidx_a_next);
      o_integ_reverse_b <=
        pol_bit(pulse_polarity_pattern_slot_b, pidx_b_next);
    end
  end

  // ****************************************************************
  // sample averaging per slot
  // ****************************************************************
  wire                  avg_a_valid;
  wire                  avg_b_valid;
  wire [`ICP_ACC_W-1:0] avg_a;
  wire [`ICP_ACC_W-1:0] avg_b;

  icp_sample_avg u_avg_a (
    .i_clk          (i_clk),
    .i_rst_b        (i_rst_b),
    .i_ce           (i_ce),
    .i_sample_valid (smp_a_valid_reg),
    .i_sample       (smp_reg),
    .i_avg_sel      (avg_sel_a),
    .o_avg_valid    (avg_a_valid),
    .o_avg          (avg_a),
    .o_count        ()
  );

  icp_sample_avg u_avg_b (
    .i_clk          (i_clk),
    .i_rst_b        (i_rst_b),
    .i_ce           (i_ce),
    .i_sample_valid (smp_b_valid_reg),
    .i_sample       (smp_reg),
    .i_avg_sel      (avg_sel_b),
    .o_avg_valid    (avg_b_valid),
    .o_avg          (avg_b),
    .o_count        ()
  );

  // ****************************************************************
  // output stage; the two slots never finish in the same cycle
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_data_valid <= 1'b0;
      o_data_slot  <= 1'b0;
      o_data       <= {`ICP_ACC_W{1'b0}};
    end else if (i_ce) begin
      o_data_valid <= avg_a_valid | avg_b_valid;
      if (avg_b_valid) begin
        o_data_slot <= 1'b1;
        o_data      <= avg_b;
      end else if (avg_a_valid) begin
        o_data_slot <= 1'b0;
        o_data      <= avg_a;
      end
    end
  end

endmodule // icp_accumulator

`default_nettype wire

// ### icp_accumulator_props.sv
// Purpose : port assertions for the chop pulse accumulator
// Assumes : bound to icp_accumulator, one clock domain
// Notes   : only top ports are visible, so counts stay in the bench
`timescale 1ns/10ps
`default_nettype none
`include "icp_accum_regs.vh"

module icp_accumulator_props (
  // clock, reset, enable
  input wire logic                  i_clk,
  input wire logic                  i_rst_b,
  input wire logic                  i_ce,
  // register port
  input wire logic                  i_reg_wr,
  input wire logic                  i_reg_rd,
  input wire logic [7:0]            i_reg_addr,
  input wire logic [15:0]           i_reg_wdata,
  input wire logic [15:0]           o_reg_rdata,
  // pulse path and outputs
  input wire logic                  i_pulse_valid,
  input wire logic                  i_pulse_slot,
  input wire logic [13:0]           i_pulse_data,
  input wire logic                  o_integ_reverse_a,
  input wire logic                  o_integ_reverse_b,
  input wire logic                  o_data_valid,
  input wire logic                  o_data_slot,
  input wire logic [`ICP_ACC_W-1:0] o_data
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_rst_clear: assert property (
    disable iff (1'b0) !i_rst_b |=> !o_data_valid && o_data == '0)
    else $error("reset left an output sample");
  chk_data_holds: assert property (
    $past(i_rst_b) && !o_data_valid |-> $stable(o_data) && $stable(o_data_slot))
    else $error("output sample moved without valid");
  // pipeline is three deep; a frozen enable would stretch it, so skip those
  chk_out_latency: assert property (
    o_data_valid && $past(i_ce) && $past(i_ce, 2) && $past(i_ce, 3)
    |-> $past(i_pulse_valid, 3) && o_data_slot == $past(i_pulse_slot, 3))
    else $error("output sample not three cycles after a pulse");
  chk_rdata_holds: assert property (
    $past(i_rst_b) && !$past(i_reg_rd && i_ce) |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (
    i_ce && i_reg_rd && !(i_reg_addr inside {8'h12, 8'h15, 8'h17,
    [8'h18:8'h1B], [8'h1D:8'h21], 8'h31, 8'h36, 8'h58, 8'h60})
    |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  chk_cfg_readback: assert property (
    i_ce && i_reg_wr && i_reg_addr == `ICP_ADDR_PULSE_CFG_A ##1
    i_ce && i_reg_rd && !i_reg_wr && i_reg_addr == `ICP_ADDR_PULSE_CFG_A
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("pulse count word not read back");
  chk_ce_freeze: assert property (
    $past(i_rst_b) && !$past(i_ce)
    |-> $stable(o_data) && $stable(o_data_valid) && $stable(o_integ_reverse_a))
    else $error("state moved with enable low");
  chk_polarity_holds: assert property (
    $past(i_rst_b) && !$past(i_reg_wr) && !$past(i_reg_wr, 2)
    && !$past(i_pulse_valid && !i_pulse_slot) |-> $stable(o_integ_reverse_a))
    else $error("slot a polarity moved without a pulse");

  // main scenarios
  cov_out_a: cover property (o_data_valid && !o_data_slot);
  cov_out_b: cover property (o_data_valid && o_data_slot);
  cov_ce_low: cover property (!i_ce && i_pulse_valid);
endmodule // icp_accumulator_props
`default_nettype wire

// ### icp_pulse_sign.v
// Purpose : signs one pulse result from its place in the four-pulse group
// Assumes : math fields already selected for the pulse's slot
// Notes   : purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "icp_accum_regs.vh"

module icp_pulse_sign (
  // pulse position and math fields
  input  wire [1:0]                    i_index,
  input  wire [1:0]                    i_math12,
  input  wire [1:0]                    i_math34,
  // pulse result in, signed term out
  input  wire signed [`ICP_TERM_W-1:0] i_result,
  output reg  signed [`ICP_TERM_W-1:0] o_term
);

  reg negate;

  // ****************************************************************
  // sign decode: upper field bit is the odd pulse, lower the even one
  // ****************************************************************
  always @* begin
    case (i_index)
      2'b00:   negate = i_math12[1];
      2'b01:   negate = i_math12[0];
      2'b10:   negate = i_math34[1];
      2'b11:   negate = i_math34[0];
      default: negate = 1'b0;
    endcase
    // inverted sequences are subtracted via the programmed math
    o_term = negate ? -i_result : i_result;
  end

endmodule // icp_pulse_sign

`default_nettype wire

// ### icp_sample_avg.v
// Purpose : sums 2^sel internal samples of one slot and emits their mean
// Assumes : at most one sample strobe per clock
// Notes   : sel of 0..7 selects 1..128 samples
`timescale 1ns/10ps
`default_nettype none
`include "icp_accum_regs.vh"

module icp_sample_avg (
  // clock, reset, enable
  input  wire                   i_clk,
  input  wire                   i_rst_b,
  input  wire                   i_ce,
  // internal samples in
  input  wire                   i_sample_valid,
  input  wire [`ICP_ACC_W-1:0]  i_sample,
  input  wire [2:0]             i_avg_sel,
  // averaged output
  output reg                    o_avg_valid,
  output reg  [`ICP_ACC_W-1:0]  o_avg,
  output reg  [6:0]             o_count
);

  wire [7:0]                  count_last;
  wire                        last;
  wire signed [`ICP_SUM_W-1:0] total;
  wire signed [`ICP_SUM_W-1:0] mean;
  reg  signed [`ICP_SUM_W-1:0] sum_reg;

  // sample count at which the group closes; >= survives a lowered sel
  assign count_last = (8'h01 << i_avg_sel) - 8'h01;
  assign last       = ({1'b0, o_count} >= count_last);
  assign total      = (o_count == 7'h00 ? {`ICP_SUM_W{1'b0}} : sum_reg)
                    + {{(`ICP_SUM_W-`ICP_ACC_W){i_sample[`ICP_ACC_W-1]}},
                       i_sample};
  assign mean       = total >>> i_avg_sel;

  // ****************************************************************
  // accumulate and emit once per group of samples
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      sum_reg     <= {`ICP_SUM_W{1'b0}};
      o_count     <= 7'h00;
      o_avg_valid <= 1'b0;
      o_avg       <= {`ICP_ACC_W{1'b0}};
    end else if (i_ce) begin
      o_avg_valid <= 1'b0;
      if (i_sample_valid) begin
        sum_reg <= total;
        if (last) begin
          o_count     <= 7'h00;
          o_avg_valid <= 1'b1;
          o_avg       <= mean[`ICP_ACC_W-1:0];
        end else begin
          o_count <= o_count + 7'h01;
        end
      end
    end
  end

endmodule // icp_sample_avg

`default_nettype wire

// ### tb.sv
// Purpose : self-checking bench for the chop pulse accumulator
// Assumes : offsets stay cleared, pulses at least one idle cycle apart
// Notes   : inputs change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
`include "icp_accum_regs.vh"

module tb;
  logic                  i_clk = 1'b0;
  logic                  i_rst_b = 1'b0;
  logic                  i_ce = 1'b1;
  logic                  i_reg_wr = 1'b0;
  logic                  i_reg_rd = 1'b0;
  logic [7:0]            i_reg_addr = 8'h00;
  logic [15:0]           i_reg_wdata = 16'h0000;
  logic [15:0]           o_reg_rdata;
  logic                  i_pulse_valid = 1'b0;
  logic                  i_pulse_slot = 1'b0;
  logic [13:0]           i_pulse_data = 14'h0000;
  logic                  o_integ_reverse_a;
  logic                  o_integ_reverse_b;
  logic                  o_data_valid;
  logic                  o_data_slot;
  logic [`ICP_ACC_W-1:0] o_data;
  int                    error_cnt = 0;
  int                    checks = 0;
  int                    cyc = 0;

  always #4 i_clk = ~i_clk;

  icp_accumulator uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_pulse_valid(i_pulse_valid), .i_pulse_slot(i_pulse_slot),
    .i_pulse_data(i_pulse_data), .o_integ_reverse_a(o_integ_reverse_a),
    .o_integ_reverse_b(o_integ_reverse_b), .o_data_valid(o_data_valid),
    .o_data_slot(o_data_slot), .o_data(o_data));

  // ****************************************************************
  // compare and bus tasks
  // ****************************************************************
  task automatic cmp_reg(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_dat(input string n, input logic [26:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // entered on a falling edge, so a read may follow a write back to back
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    @(negedge i_clk);
    cmp_reg("o_reg_rdata", e, o_reg_rdata);
  endtask
  // checks the polarity offered for this pulse before sending it
  task automatic pulse(input logic s, input logic [13:0] d, input logic r);
    @(negedge i_clk);
    cmp_dat("o_integ_reverse", {26'h0, r},
      {26'h0, s ? o_integ_reverse_b : o_integ_reverse_a});
    i_pulse_valid = 1'b1;
    i_pulse_slot = s;
    i_pulse_data = d;
    @(negedge i_clk);
    i_pulse_valid = 1'b0;
  endtask
  task automatic get_out(input logic s, input logic [26:0] e);
    int n;
    n = 0;
    while (o_data_valid !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    cmp_dat("o_data_valid", 27'h000_0001, {26'h0, o_data_valid});
    cmp_dat("o_data_slot", {26'h0, s}, {26'h0, o_data_slot});
    cmp_dat("o_data", e, o_data);
  endtask
  task automatic quiet(input int c);
    int v;
    v = 0;
    repeat (c) begin
      @(negedge i_clk);
      v += (o_data_valid === 1'b1);
    end
    cmp_dat("early valids", 27'h000_0000, 27'(v));
  endtask

  // ****************************************************************
  // scenarios, offset registers left cleared
  // ****************************************************************
  task automatic t_regs;
    rd(`ICP_ADDR_PULSE_CFG_A, 16'h0000);
    wr(`ICP_ADDR_PULSE_CFG_A, 16'h0200);
    rd(`ICP_ADDR_PULSE_CFG_A, 16'h0200);
    rd(8'h40, 16'h0000);
    wr(8'h20, 16'h0003);
    rd(8'h20, 16'h0003);
    wr(8'h20, 16'h0000);
  endtask
  task automatic t_walk;
    pulse(1'b0, 14'h0005, 1'b0);
    rd(`ICP_ADDR_STATUS, 16'h0001);
    pulse(1'b0, 14'h0007, 1'b0);
    get_out(1'b0, 27'h000_000c);
    pulse(1'b0, 14'h0001, 1'b0);
    pulse(1'b0, 14'h0002, 1'b0);
    get_out(1'b0, 27'h000_0003);
  endtask
  // eight pulses, a multiple of four, so each sign code repeats over two groups
  task automatic t_math;
    int e;
    logic b;
    wr(`ICP_ADDR_PULSE_CFG_A, 16'h0800);
    wr(`ICP_ADDR_POLARITY_A, 16'h000a);
    for (int m = 0; m < 4; m++) begin
      wr(`ICP_ADDR_CHOP_MATH, 16'(m << 1 | m << 8));
      e = 0;
      for (int k = 1; k <= 8; k++) begin
        b = ((k - 1) % 2 == 0) ? m[1] : m[0];
        e = b ? e - 10 * k : e + 10 * k;
        pulse(1'b0, 14'(10 * k), 1'(4'ha >> ((k - 1) % 4)));
      end
      get_out(1'b0, 27'(e));
    end
  endtask
  task automatic t_slot_b;
    wr(`ICP_ADDR_PULSE_CFG_B, 16'h0400);
    wr(`ICP_ADDR_POLARITY_B, 16'h0005);
    wr(`ICP_ADDR_CHOP_MATH, 16'h0840);
    for (int k = 1; k <= 4; k++) begin
      pulse(1'b1, 14'(k), 1'(4'h5 >> (k - 1)));
    end
    get_out(1'b1, 27'h000_0002);
  endtask
  // four samples averaged; a pulse offered with enable low must be ignored
  task automatic t_avg;
    wr(`ICP_ADDR_SAMPLE_FREQ, 16'h0190);
    wr(`ICP_ADDR_PULSE_CFG_A, 16'h0100);
    wr(`ICP_ADDR_AVG_COUNT, 16'h0020);
    i_ce = 1'b0;
    i_pulse_valid = 1'b1;
    i_pulse_slot = 1'b0;
    i_pulse_data = 14'h0064;
    @(negedge i_clk);
    i_ce = 1'b1;
    i_pulse_valid = 1'b0;
    for (int k = 1; k <= 3; k++) begin
      pulse(1'b0, 14'(4 * k), 1'b0);
      quiet(6);
    end
    pulse(1'b0, 14'h0010, 1'b0);
    get_out(1'b0, 27'h000_000a);
  endtask

  task automatic complete_run;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      complete_run;
    end
  end

  initial begin
    repeat (3) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_regs;
    t_walk;
    t_math;
    t_slot_b;
    t_avg;
    complete_run;
  end
endmodule // tb

bind icp_accumulator icp_accumulator_props u_props (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_pulse_valid(i_pulse_valid),
  .i_pulse_slot(i_pulse_slot), .i_pulse_data(i_pulse_data),
  .o_integ_reverse_a(o_integ_reverse_a),
  .o_integ_reverse_b(o_integ_reverse_b), .o_data_valid(o_data_valid),
  .o_data_slot(o_data_slot), .o_data(o_data));
`default_nettype wire
